// file: core/sncr_defs.vh
// register offsets, field positions and reset values of the node config block
`ifndef SNCR_DEFS_VH
`define SNCR_DEFS_VH
`define SNCR_ADDR_W          8
`define SNCR_OFF_SW_CFG      8'h04
`define SNCR_OFF_NODE_ID     8'h05
`define SNCR_OFF_PLL         8'h06
`define SNCR_OFF_SW_DIV      8'h07
`define SNCR_OFF_REF_DIV     8'h08
`define SNCR_OFF_DEV_ID      8'h09
`define SNCR_OFF_USER_CODE   8'h0A
`define SNCR_OFF_DIR_LOW     8'h0C
`define SNCR_OFF_DIR_HIGH    8'h0D
`define SNCR_OFF_SPARE_A     8'h10
`define SNCR_OFF_SPARE_B     8'h11
`define SNCR_OFF_DBG_SRC     8'h1F
`define SNCR_OFF_LINK_FIRST  8'h20
`define SNCR_OFF_LINK_LAST   8'h28
`define SNCR_NUM_LINKS       9
`define SNCR_PLL_NO_RESET    31
`define SNCR_PLL_NO_WAIT     30
`define SNCR_PLL_BYPASS      29
`define SNCR_PLL_JTAG_BOOT   28
`define SNCR_PLL_MASK        32'hF39F_FF7F
`define SNCR_PLL_RESET       32'h0000_0000
`define SNCR_CFG_PLL_LOCK    8
`define SNCR_CFG_MASK        32'h8000_0101
`define SNCR_SW_DIV_RESET    16'h0000
`define SNCR_REF_DIV_RESET   16'h0003
`define SNCR_LINK_DIR_LSB    8
`define SNCR_LINK_NET_LSB    4
`define SNCR_DBG_MASK        32'h0000_0013
`define SNCR_SPARE_MASK      32'h0000_0003
`define SNCR_DEV_ID_VALUE    32'h0000_0001 // arbitrary value
`define SNCR_TILE_RST_CYC    4'h8
`endif

// file: core/sncr_regs.v
// configuration and status register bank of the node packet switch
// Overview of operation
// - pll control write resets tile unless no-reset
// - bit31 set applies pll without tile reset
// - bit30 set skips waiting for pll relock
// - bit29 set bypasses the pll
// - bit28 set selects boot over scan port
// - post divider in bits 25:23, 0..7
// - feedback multiplier in bits 20:8
// - input divider in bits 6:0
// - switch clock divider 16 bits, reset 0
// - reference clock divider 16 bits, reset 3
// - user code otp 31:18, metal id 17:0
// - route by most significant id mismatch bit
// - low table nibbles for positions 7..0
// - high table nibbles for positions 15..8
// - debug source flags core one or zero
// - link status 25:24 gives source target type
// - link status 23:16 gives destination link
// - link direction field 11:8, reset 0
// - link network field 5:4, reset 0
// - bit 2 shows junk packet on link
// - bits 1,0 show dest and source in use
// - config lock bit 8 blocks pll writes
// - node identifier 16 bits, reset zero
`include "sncr_defs.vh"
module sncr_regs
(
   input  wire        SYS_CLK_I,
   input  wire        RST_N_I,
   input  wire        CFG_WR_I,
   input  wire        CFG_RD_I,
   input  wire [7:0]  CFG_ADDR_I,
   input  wire [31:0] CFG_WDATA_I,
   output reg  [31:0] CFG_RDATA_O,
   output reg         CFG_RVALID_O,
   input  wire        PLL_LOCK_I,
   input  wire [13:0] OTP_USER_CODE_I,
   input  wire [17:0] METAL_ID_I,
   input  wire        DBG_EVENT_I,
   input  wire        DBG_CORE_ONE_I,
   input  wire [15:0] PKT_DEST_I,
   input  wire [8:0]  LINK_SRC_BUSY_I,
   input  wire [8:0]  LINK_DST_BUSY_I,
   input  wire [8:0]  LINK_JUNK_I,
   input  wire [17:0] LINK_SRC_TYPE_I,
   input  wire [71:0] LINK_DEST_NUM_I,
   output reg  [31:0] PLL_CTRL_O,
   output reg  [15:0] SW_CLK_DIV_O,
   output reg  [15:0] REF_CLK_DIV_O,
   output reg         TILE_RESET_O,
   output reg  [3:0]  ROUTE_DIR_O,
   output reg         ROUTE_LOCAL_O,
   output reg  [35:0] LINK_DIR_O,
   output reg  [17:0] LINK_NET_O
);

   reg  [31:0] sw_cfg;
   reg  [15:0] node_id;
   reg  [31:0] dir_low;
   reg  [31:0] dir_high;
   reg  [31:0] spare_a;
   reg  [31:0] spare_b;
   reg  [31:0] dbg_src;
   reg  [1:0]  lock_meta;
   reg  [1:0]  lock_sync;
   reg  [3:0]  rst_cnt;
   reg         wait_lock;
   reg  [31:0] rd_mux;
   reg  [3:0]  next_dir;
   reg         next_local;
   wire [15:0] diff;
   wire [63:0] dir_all;
   wire [15:0] pos_win;
   wire [67:0] dir_or;
   wire [3:0]  link_idx;
   wire        link_hit;
   wire        pll_wr;

   assign link_idx = CFG_ADDR_I[3:0];
   assign link_hit = (CFG_ADDR_I >= `SNCR_OFF_LINK_FIRST) &&
                     (CFG_ADDR_I <= `SNCR_OFF_LINK_LAST);
   // locked configuration ignores pll writes
   assign pll_wr = CFG_WR_I && (CFG_ADDR_I == `SNCR_OFF_PLL) &&
                   !sw_cfg[`SNCR_CFG_PLL_LOCK];

   // pll lock status synchroniser
   always @(posedge SYS_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         lock_meta <= 2'b00;
         lock_sync <= 2'b00;
      end
      else
      begin
         lock_meta <= {lock_meta[0], PLL_LOCK_I};
         lock_sync <= {lock_sync[0], lock_meta[1]};
      end
   end

   // plain read/write registers
   always @(posedge SYS_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         sw_cfg        <= 32'h0000_0000;
         node_id       <= 16'h0000;
         PLL_CTRL_O    <= `SNCR_PLL_RESET;
         SW_CLK_DIV_O  <= `SNCR_SW_DIV_RESET;
         REF_CLK_DIV_O <= `SNCR_REF_DIV_RESET;
         dir_low       <= 32'h0000_0000;
         dir_high      <= 32'h0000_0000;
         spare_a       <= 32'h0000_0000;
         spare_b       <= 32'h0000_0000;
      end
      else if (CFG_WR_I)
      begin
         case (CFG_ADDR_I)
            `SNCR_OFF_SW_CFG:
               sw_cfg <= CFG_WDATA_I & `SNCR_CFG_MASK;
            `SNCR_OFF_NODE_ID:
               node_id <= CFG_WDATA_I[15:0];
            `SNCR_OFF_PLL:
               if (pll_wr)
                  // fields 25:23, 20:8, 6:0 and flags 31:28
                  PLL_CTRL_O <= CFG_WDATA_I & `SNCR_PLL_MASK;
            `SNCR_OFF_SW_DIV:
               SW_CLK_DIV_O <= CFG_WDATA_I[15:0];
            `SNCR_OFF_REF_DIV:
               REF_CLK_DIV_O <= CFG_WDATA_I[15:0];
            `SNCR_OFF_DIR_LOW:
               dir_low <= CFG_WDATA_I;
            `SNCR_OFF_DIR_HIGH:
               dir_high <= CFG_WDATA_I;
            `SNCR_OFF_SPARE_A:
               spare_a <= CFG_WDATA_I & `SNCR_SPARE_MASK;
            `SNCR_OFF_SPARE_B:
               spare_b <= CFG_WDATA_I & `SNCR_SPARE_MASK;
            default:
               sw_cfg <= sw_cfg;
         endcase
      end
   end

   // tile reset sequencer after a pll write
   always @(posedge SYS_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         TILE_RESET_O <= 1'b0;
         rst_cnt      <= 4'h0;
         wait_lock    <= 1'b0;
      end
      else if (pll_wr && !CFG_WDATA_I[`SNCR_PLL_NO_RESET])
      begin
         // no-reset bit applies the setting live instead
         TILE_RESET_O <= 1'b1;
         rst_cnt      <= `SNCR_TILE_RST_CYC;
         wait_lock    <= !CFG_WDATA_I[`SNCR_PLL_NO_WAIT];
      end
      else if (rst_cnt != 4'h0)
         rst_cnt <= rst_cnt - 4'h1;
      else if (TILE_RESET_O && (!wait_lock || lock_sync[1]))
      begin
         TILE_RESET_O <= 1'b0;
         wait_lock    <= 1'b0;
      end
   end
   // bypass and scan boot bits leave on PLL_CTRL_O[29:28]
   // multiplier and input divider leave on PLL_CTRL_O

   // debug source capture
   always @(posedge SYS_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         dbg_src <= 32'h0000_0000;
      else if (DBG_EVENT_I)
         dbg_src <= {30'h0000_0000, DBG_CORE_ONE_I,
                     !DBG_CORE_ONE_I};
      else if (CFG_WR_I && CFG_ADDR_I == `SNCR_OFF_DBG_SRC)
         dbg_src <= CFG_WDATA_I & `SNCR_DBG_MASK;
   end

   // per-link direction and network fields
   genvar g;
   generate
      for (g = 0; g < `SNCR_NUM_LINKS; g = g + 1)
      begin : g_link
         always @(posedge SYS_CLK_I or negedge RST_N_I)
         begin
            if (!RST_N_I)
            begin
               LINK_DIR_O[4*g+3:4*g] <= 4'h0;
               LINK_NET_O[2*g+1:2*g] <= 2'b00;
            end
            else if (CFG_WR_I && link_hit && link_idx == g)
            begin
               LINK_DIR_O[4*g+3:4*g] <= CFG_WDATA_I[11:8];
               LINK_NET_O[2*g+1:2*g] <= CFG_WDATA_I[5:4];
            end
         end
      end
   endgenerate

   // route lookup on most significant mismatch
   assign diff    = PKT_DEST_I ^ node_id;
   assign dir_all = {dir_high, dir_low};

   // a position claims the route only when no higher bit differs
   genvar p;
   generate
      for (p = 0; p < 16; p = p + 1)
      begin : g_pos
         if (p == 15)
         begin : g_top
            assign pos_win[p] = diff[p];
         end
         else
         begin : g_rest
            assign pos_win[p] = diff[p] && !(|diff[15:p+1]);
         end
         assign dir_or[4*p+7:4*p+4] = dir_or[4*p+3:4*p] |
            (dir_all[4*p+3:4*p] & {4{pos_win[p]}});
      end
   endgenerate
   assign dir_or[3:0] = 4'h0;

   always @*
   begin
      next_dir   = dir_or[67:64];
      next_local = !(|diff);
   end

   always @(posedge SYS_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         ROUTE_DIR_O   <= 4'h0;
         ROUTE_LOCAL_O <= 1'b1;
      end
      else
      begin
         ROUTE_DIR_O   <= next_dir;
         ROUTE_LOCAL_O <= next_local;
      end
   end

   // read multiplexer
   always @*
   begin
      rd_mux = 32'h0000_0000;
      case (CFG_ADDR_I)
         `SNCR_OFF_SW_CFG:   rd_mux = sw_cfg;
         `SNCR_OFF_NODE_ID:  rd_mux = {16'h0000, node_id};
         `SNCR_OFF_PLL:      rd_mux = PLL_CTRL_O;
         `SNCR_OFF_SW_DIV:   rd_mux = {16'h0000, SW_CLK_DIV_O};
         `SNCR_OFF_REF_DIV:  rd_mux = {16'h0000, REF_CLK_DIV_O};
         `SNCR_OFF_DEV_ID:   rd_mux = `SNCR_DEV_ID_VALUE;
         `SNCR_OFF_USER_CODE:
            rd_mux = {OTP_USER_CODE_I, METAL_ID_I};
         `SNCR_OFF_DIR_LOW:  rd_mux = dir_low;
         `SNCR_OFF_DIR_HIGH: rd_mux = dir_high;
         `SNCR_OFF_SPARE_A:  rd_mux = spare_a;
         `SNCR_OFF_SPARE_B:  rd_mux = spare_b;
         `SNCR_OFF_DBG_SRC:  rd_mux = dbg_src;
         default:
            if (link_hit)
               rd_mux = {6'h00,
                         LINK_SRC_TYPE_I[2*link_idx +: 2],
                         LINK_DEST_NUM_I[8*link_idx +: 8],
                         4'h0, LINK_DIR_O[4*link_idx +: 4],
                         2'b00, LINK_NET_O[2*link_idx +: 2], 1'b0,
                         LINK_JUNK_I[link_idx],
                         LINK_DST_BUSY_I[link_idx],
                         LINK_SRC_BUSY_I[link_idx]};
      endcase
   end

   always @(posedge SYS_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         CFG_RDATA_O  <= 32'h0000_0000;
         CFG_RVALID_O <= 1'b0;
      end
      else
      begin
         CFG_RVALID_O <= CFG_RD_I;
         if (CFG_RD_I)
            CFG_RDATA_O <= rd_mux;
      end
   end

endmodule // sncr_regs

// file: testbench/sncr_regs_chk.sv
// assertion checker for the node config register bank
module sncr_regs_chk
(
   input wire logic        SYS_CLK_I,
   input wire logic        RST_N_I,
   input wire logic        CFG_WR_I,
   input wire logic        CFG_RD_I,
   input wire logic [7:0]  CFG_ADDR_I,
   input wire logic [31:0] CFG_WDATA_I,
   input wire logic [31:0] CFG_RDATA_O,
   input wire logic        CFG_RVALID_O,
   input wire logic        PLL_LOCK_I,
   input wire logic [13:0] OTP_USER_CODE_I,
   input wire logic [17:0] METAL_ID_I,
   input wire logic [15:0] PKT_DEST_I,
   input wire logic [31:0] PLL_CTRL_O,
   input wire logic [15:0] SW_CLK_DIV_O,
   input wire logic        TILE_RESET_O,
   input wire logic        ROUTE_LOCAL_O
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        lk;
   logic        skip;
   logic [15:0] nid;
   wire         wr6 = CFG_WR_I && CFG_ADDR_I == 8'h06 && !lk;
   // shadow of lock bit, node id and last relock choice
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
      if (!RST_N_I)
      begin
         lk <= 1'b0;
         skip <= 1'b0;
         nid <= 16'h0000;
      end
      else
      begin
         if (CFG_WR_I && CFG_ADDR_I == 8'h04)
            lk <= CFG_WDATA_I[8];
         if (CFG_WR_I && CFG_ADDR_I == 8'h05)
            nid <= CFG_WDATA_I[15:0];
         if (wr6 && !CFG_WDATA_I[31])
            skip <= CFG_WDATA_I[30];
      end
   default clocking @(posedge SYS_CLK_I);
   endclocking
   default disable iff (!RST_N_I);
   a_pll_write_reset: assert property (
      wr6 && !CFG_WDATA_I[31] |=> TILE_RESET_O)
      else $error("tile reset missing after pll write");
   a_pll_lock_block: assert property (
      CFG_WR_I && CFG_ADDR_I == 8'h06 && lk |=> $stable(PLL_CTRL_O))
      else $error("locked pll word changed");
   a_pll_field_update: assert property (
      wr6 |=> PLL_CTRL_O == ($past(CFG_WDATA_I) & 32'hF39F_FF7F))
      else $error("pll word not taken");
   a_tile_hold_min: assert property (
      $rose(TILE_RESET_O) |-> TILE_RESET_O [*8])
      else $error("tile reset too short");
   a_relock_wait: assert property (
      TILE_RESET_O && !skip && !PLL_LOCK_I && !$past(PLL_LOCK_I) &&
      !$past(PLL_LOCK_I, 2) |=> TILE_RESET_O)
      else $error("tile reset dropped without lock");
   a_user_code_read: assert property (
      CFG_RD_I && CFG_ADDR_I == 8'h0A |=> CFG_RVALID_O &&
      CFG_RDATA_O == {$past(OTP_USER_CODE_I), $past(METAL_ID_I)})
      else $error("user code read wrong");
   a_sw_div_follow: assert property (
      CFG_WR_I && CFG_ADDR_I == 8'h07 |=>
      {16'h0000, SW_CLK_DIV_O} == ($past(CFG_WDATA_I) & 32'h0000_FFFF))
      else $error("switch divider not taken");
   a_route_local: assert property (
      1'b1 |=> ROUTE_LOCAL_O == ($past(PKT_DEST_I) == $past(nid)))
      else $error("local match wrong");
endmodule // sncr_regs_chk
bind sncr_regs sncr_regs_chk chk_i
(
   .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .CFG_WR_I(CFG_WR_I),
   .CFG_RD_I(CFG_RD_I), .CFG_ADDR_I(CFG_ADDR_I), .CFG_WDATA_I(CFG_WDATA_I),
   .CFG_RDATA_O(CFG_RDATA_O), .CFG_RVALID_O(CFG_RVALID_O),
   .PLL_LOCK_I(PLL_LOCK_I), .OTP_USER_CODE_I(OTP_USER_CODE_I),
   .METAL_ID_I(METAL_ID_I), .PKT_DEST_I(PKT_DEST_I), .PLL_CTRL_O(PLL_CTRL_O),
   .SW_CLK_DIV_O(SW_CLK_DIV_O), .TILE_RESET_O(TILE_RESET_O),
   .ROUTE_LOCAL_O(ROUTE_LOCAL_O)
);

// file: testbench/test_sncr_regs.sv
// self-checking bench for the node config register bank
module test_sncr_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 0, rst_n = 0, wr = 0, rd = 0, lock = 0, dev = 0, dc1 = 0;
   logic [7:0]  a = 8'h00;
   logic [31:0] wd = 32'h0000_0000, rdo, pll;
   logic [13:0] otp = 14'h2A5C;
   logic [17:0] mid = 18'h1_2345, st = 18'h0_0000, lnet;
   logic [15:0] dst = 16'h0000, swd, rfd;
   logic [8:0]  sb = 9'h000, db = 9'h000, jk = 9'h000;
   logic [71:0] dn = 72'h0;
   logic [35:0] ldir;
   logic [3:0]  rdir;
   logic        rv, trst, loc;
   int          err_count = 0, n_compared = 0;
   always #12.5 clk = ~clk;
   sncr_regs dut
   (
      .SYS_CLK_I(clk), .RST_N_I(rst_n), .CFG_WR_I(wr), .CFG_RD_I(rd),
      .CFG_ADDR_I(a), .CFG_WDATA_I(wd), .CFG_RDATA_O(rdo), .CFG_RVALID_O(rv),
      .PLL_LOCK_I(lock), .OTP_USER_CODE_I(otp), .METAL_ID_I(mid),
      .DBG_EVENT_I(dev), .DBG_CORE_ONE_I(dc1), .PKT_DEST_I(dst),
      .LINK_SRC_BUSY_I(sb), .LINK_DST_BUSY_I(db), .LINK_JUNK_I(jk),
      .LINK_SRC_TYPE_I(st), .LINK_DEST_NUM_I(dn), .PLL_CTRL_O(pll),
      .SW_CLK_DIV_O(swd), .REF_CLK_DIV_O(rfd), .TILE_RESET_O(trst),
      .ROUTE_DIR_O(rdir), .ROUTE_LOCAL_O(loc), .LINK_DIR_O(ldir),
      .LINK_NET_O(lnet)
   );
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task wrr(input logic [7:0] ad, input logic [31:0] d);
      @(negedge clk);
      wr = 1;
      a = ad;
      wd = d;
      @(negedge clk);
      wr = 0;
   endtask
   task rdc(input string n, input logic [7:0] ad, input logic [31:0] e);
      @(negedge clk);
      rd = 1;
      a = ad;
      @(negedge clk);
      rd = 0;
      chk("read valid", 32'h0000_0001, {31'h0, rv});
      chk(n, e, rdo);
   endtask
   task t_reset;
      rdc("pll", 8'h06, 32'h0000_0000);
      rdc("refdiv", 8'h08, 32'h0000_0003);
      rdc("usercode", 8'h0A, {otp, mid});
      rdc("unmapped", 8'h0B, 32'h0000_0000);
      chk("ref port", 32'h0000_0003, {16'h0000, rfd});
   endtask
   task t_rw;
      logic [7:0]  ad [7] = '{8'h05, 8'h07, 8'h08, 8'h0C, 8'h0D, 8'h10, 8'h11};
      logic [31:0] m [7] = '{32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_FFFF,
         32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_0003, 32'h0000_0003};
      logic [31:0] r [7] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0003,
         32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
      foreach (ad[i])
      begin
         rdc("reset value", ad[i], r[i]);
         wrr(ad[i], 32'hFFFF_FFFF);
         rdc("rw field", ad[i], m[i]);
      end
      chk("sw div port", 32'h0000_FFFF, {16'h0000, swd});
      wrr(8'h0A, 32'h0000_0000);
      rdc("ro usercode", 8'h0A, {otp, mid});
   endtask
   task t_route;
      wrr(8'h05, 32'h0000_0000);
      wrr(8'h0C, 32'h7654_3210);
      wrr(8'h0D, 32'hFEDC_BA98);
      for (int n = 0; n < 16; n++)
      begin
         dst = (16'h0001 << n) | 16'h0001;
         @(negedge clk);
         @(negedge clk);
         chk("route dir", n, {28'h0, rdir});
      end
      dst = 16'h0000;
      @(negedge clk);
      @(negedge clk);
      chk("local", 32'h0000_0001, {31'h0, loc});
      wrr(8'h05, 32'h0000_8000);
      @(negedge clk);
      chk("far dir", 32'h0000_000F, {28'h0, rdir});
      chk("not local", 32'h0000_0000, {31'h0, loc});
   endtask
   task t_pll;
      wrr(8'h06, 32'h7FFF_FFFF);
      chk("tile reset", 32'h0000_0001, {31'h0, trst});
      chk("pll port", 32'h739F_FF7F, pll);
      repeat (20) @(negedge clk);
      chk("skip relock", 32'h0000_0000, {31'h0, trst});
      wrr(8'h06, 32'h2012_3405);
      repeat (30) @(negedge clk);
      chk("wait lock", 32'h0000_0001, {31'h0, trst});
      lock = 1;
      repeat (6) @(negedge clk);
      chk("locked", 32'h0000_0000, {31'h0, trst});
      wrr(8'h06, 32'h9000_0000);
      chk("no reset", 32'h0000_0000, {31'h0, trst});
      chk("boot port", 32'h9000_0000, pll);
      wrr(8'h04, 32'h7FFF_FFFF);
      rdc("swcfg", 8'h04, 32'h0000_0101);
      wrr(8'h06, 32'h0000_0001);
      rdc("locked pll", 8'h06, 32'h9000_0000);
      chk("locked trst", 32'h0000_0000, {31'h0, trst});
      wrr(8'h04, 32'h0000_0000);
   endtask
   task t_link;
      sb = 9'h101;
      db = 9'h100;
      jk = 9'h100;
      st = 18'h2_0001;
      dn = {8'hA5, 64'h0};
      wrr(8'h20, 32'hFFFF_FFFF);
      wrr(8'h28, 32'hFFFF_FFFF);
      rdc("link0", 8'h20, 32'h0100_0F31);
      rdc("link8", 8'h28, 32'h02A5_0F37);
      chk("dir port", 32'hF000_000F, {ldir[35:32], 24'h0, ldir[3:0]});
      chk("net port", 32'hC000_0003, {lnet[17:16], 28'h0, lnet[1:0]});
   endtask
   task t_dbg;
      dev = 1;
      dc1 = 1;
      @(negedge clk);
      dev = 0;
      rdc("dbg one", 8'h1F, 32'h0000_0002);
      dev = 1;
      dc1 = 0;
      @(negedge clk);
      dev = 0;
      rdc("dbg zero", 8'h1F, 32'h0000_0001);
   endtask
   task print_verdict;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(negedge clk);
      rst_n = 1;
      t_reset;
      t_rw;
      t_route;
      t_pll;
      t_link;
      t_dbg;
      print_verdict;
   end
   // watchdog well beyond the expected run length
   initial
   begin
      #100us;
      err_count++;
      print_verdict;
   end
endmodule // test_sncr_regs
